// [hdl/nv_control_top.sv]
// two-wire register front end for the nonvolatile configuration memory
`include "nv_control_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module nv_control_top import nv_control_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h5A,
  parameter int ERASE_CYCLES = `NV_ERASE_CYCLES,
  parameter int PROG_CYCLES = `NV_PROG_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [4:0] cfg_addr_o,
  output logic [7:0] cfg_data_o,
  output logic cfg_we_o,
  input wire logic [7:0] cfg_rdata_i
);
  nv_link_if link ();

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic scl_d;
  logic sda_d;
  i2c_state_type ist;
  logic [2:0] bitcnt;
  logic got_byte;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic rw;
  logic first_wr;
  logic mack_ok;
  logic sda_oe;
  logic [7:0] ptr;
  logic lock;
  logic [4:0] rd_ptr;
  logic txn_unlock;
  logic key_armed;
  logic save_bit;
  logic load_bit;
  logic auto_crc;
  logic [6:0] start_addr;
  logic [7:0] unlock_key;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_ev;
  logic addr_ok;
  logic ptr_ev;
  logic wr_ev;
  logic fetch_ev;
  logic hit_ctrl;
  logic hit_start;
  logic hit_data;
  logic hit_unlock;
  logic hit_count;
  logic ctrl_wr;
  logic key_ok;
  logic [4:0] fetch_addr;
  logic [7:0] next_ptr;
  logic [7:0] ctrl_value;
  logic [7:0] data_value;
  logic [7:0] rd_value;

  nv_engine #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_engine (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .link(link)
  );

  // pin synchronisers; a level is taken once the second and third stages agree
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      scl_q <= (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
      sda_q <= (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  // bus events
  assign scl_rise = scl_q && !scl_d;
  assign scl_fall = !scl_q && scl_d;
  assign start_det = scl_q && scl_d && sda_d && !sda_q;
  assign stop_det = scl_q && scl_d && !sda_d && sda_q;
  assign byte_ev = scl_fall && got_byte;
  // refuse a read address while loading
  assign addr_ok = shreg[7:1] == DEV_ADDR && !(shreg[0] && link.loading);
  assign ptr_ev = byte_ev && ist == I_WRITE && first_wr;
  assign wr_ev = byte_ev && ist == I_WRITE && !first_wr;
  assign fetch_ev = scl_fall && ((ist == I_ACK && rw) || (ist == I_MACK && mack_ok));

  // register decode
  assign hit_ctrl = ptr == `NV_REG_CONTROL;
  assign hit_start = ptr == `NV_REG_START;
  assign hit_data = ptr == `NV_REG_DATA;
  assign hit_unlock = ptr == `NV_REG_UNLOCK;
  assign hit_count = ptr == `NV_REG_COUNTER;
  assign ctrl_wr = wr_ev && hit_ctrl;
  assign key_ok = key_armed && link.idle;
  assign link.erase_go = ctrl_wr && shreg[`NV_CTL_ERASE] && key_ok;
  assign link.prog_go = ctrl_wr && shreg[`NV_CTL_PROG] && key_ok;

  // low five start bits address the array
  assign fetch_addr = lock ? rd_ptr + 5'h01 : start_addr[4:0];
  // pointer held on the data register
  assign next_ptr = hit_data ? ptr : ptr + 8'h01;
  assign link.rd_addr = fetch_addr;

  // read mux; busy makes the data register read zero
  assign ctrl_value = {1'b0, save_bit, link.crc_error, auto_crc, load_bit, link.busy, 2'h0};
  assign data_value = link.busy ? 8'h00 : link.rd_data;
  assign rd_value = hit_ctrl ? ctrl_value :
                    hit_start ? {1'b0, start_addr} :
                    hit_data ? data_value :
                    hit_unlock ? unlock_key :
                    hit_count ? link.cycle_count : 8'h00;

  // engine requests and live register path
  assign link.save_req = save_bit;
  assign link.load_req = load_bit;
  assign link.auto_crc = auto_crc;
  assign link.cfg_rdata = cfg_rdata_i;
  assign cfg_addr_o = link.cfg_addr;
  assign cfg_data_o = link.cfg_data;
  assign cfg_we_o = link.cfg_we;
  assign sda_oe_o = sda_oe;

  // sda only ever pulls low, so the data output is a constant-low flop
  always_ff @(posedge clock_i) begin
    sda_o <= 1'b0;
  end

  // bit engine: sample on scl rise, change sda on scl fall
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ist <= I_IDLE;
      bitcnt <= 3'h0;
      got_byte <= 1'b0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      rw <= 1'b0;
      first_wr <= 1'b0;
      mack_ok <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      ist <= I_ADDR;
      bitcnt <= 3'h0;
      got_byte <= 1'b0;
      first_wr <= 1'b1;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      ist <= I_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (ist)
        I_ADDR, I_WRITE, I_READ: begin
          shreg <= {shreg[6:0], sda_q};
          bitcnt <= bitcnt + 3'h1;
          got_byte <= bitcnt == 3'h7;
        end
        I_MACK: begin
          mack_ok <= !sda_q;
          ist <= sda_q ? I_IDLE : I_MACK;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (ist)
        I_ADDR: begin
          if (got_byte) begin
            got_byte <= 1'b0;
            ist <= addr_ok ? I_ACK : I_IDLE;
            sda_oe <= addr_ok;
            rw <= shreg[0];
          end
        end
        I_WRITE: begin
          if (got_byte) begin
            got_byte <= 1'b0;
            first_wr <= 1'b0;
            ist <= I_ACK;
            sda_oe <= 1'b1;
          end
        end
        I_ACK, I_MACK: begin
          bitcnt <= 3'h0;
          if (rw) begin
            ist <= I_READ;
            txreg <= rd_value;
            sda_oe <= !rd_value[7];
          end else begin
            ist <= I_WRITE;
            sda_oe <= 1'b0;
          end
        end
        I_READ: begin
          if (got_byte) begin
            got_byte <= 1'b0;
            sda_oe <= 1'b0;
            ist <= I_MACK;
          end else begin
            txreg <= {txreg[6:0], 1'b0};
            sda_oe <= !txreg[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // pointer, data lock and unlock tracking; stop ends the transaction
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ptr <= 8'h00;
      lock <= 1'b0;
      rd_ptr <= 5'h00;
      txn_unlock <= 1'b0;
      key_armed <= 1'b0;
    end else if (stop_det) begin
      lock <= 1'b0;
      key_armed <= txn_unlock;
      txn_unlock <= 1'b0;
    end else begin
      if (ptr_ev) begin
        ptr <= shreg;
      end
      if (wr_ev || fetch_ev) begin
        ptr <= next_ptr;
      end
      if (wr_ev && hit_unlock && shreg == `NV_UNLOCK_KEY) begin
        txn_unlock <= 1'b1;
      end
      // later reads take the next one
      if (fetch_ev && hit_data) begin
        lock <= 1'b1;
        rd_ptr <= fetch_addr;
      end
    end
  end

  // software-visible bits; the erase and program bits are never stored
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      save_bit <= 1'b0;
      load_bit <= 1'b0;
      auto_crc <= `NV_AUTOCRC_RESET;
      start_addr <= `NV_START_RESET;
      unlock_key <= 8'h00;
    end else begin
      save_bit <= (ctrl_wr && shreg[`NV_CTL_SAVE]) || (save_bit && !link.save_done);
      load_bit <= (ctrl_wr && shreg[`NV_CTL_LOAD]) || (load_bit && !link.load_done);
      auto_crc <= ctrl_wr ? shreg[`NV_CTL_AUTOCRC] : auto_crc;
      start_addr <= (wr_ev && hit_start) ? shreg[6:0] : start_addr;
      unlock_key <= (wr_ev && hit_unlock) ? shreg : unlock_key;
    end
  end

  key_gate_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (ctrl_wr && (shreg[1] || shreg[0]) && !key_armed && !link.busy) |=> !link.busy)
    else $error("cycle started without key");
  load_nack_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (ist == I_ADDR && byte_ev && shreg[0] && link.loading) |=> !sda_oe && ist == I_IDLE)
    else $error("read acked during load");
  ptr_lock_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (fetch_ev && hit_data) |=> ptr == $past(ptr) && lock) else $error("pointer moved");
  stop_end_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    stop_det |=> !lock) else $error("lock survived stop");
  next_byte_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (fetch_ev && lock && hit_data) |=> rd_ptr == $past(rd_ptr) + 5'h01 && start_addr == $past(start_addr))
    else $error("internal address wrong");
  first_byte_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (fetch_ev && hit_data && !lock && !link.busy) |=>
    txreg == $past(link.rd_data) && rd_ptr == $past(start_addr[4:0])) else $error("first byte wrong");
  auto_inc_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (wr_ev && !hit_data) |=> ptr == $past(ptr) + 8'h01) else $error("no auto-increment");
endmodule : nv_control_top
`default_nettype wire

// [pkg/nv_control_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef NV_CONTROL_REGS_SVH
`define NV_CONTROL_REGS_SVH
`define NV_REG_COUNTER 8'h30
`define NV_REG_CONTROL 8'h31
`define NV_REG_START 8'h33
`define NV_REG_DATA 8'h34
`define NV_REG_UNLOCK 8'h38
`define NV_CTL_SAVE 6
`define NV_CTL_CRCERR 5
`define NV_CTL_AUTOCRC 4
`define NV_CTL_LOAD 3
`define NV_CTL_BUSY 2
`define NV_CTL_ERASE 1
`define NV_CTL_PROG 0
`define NV_AUTOCRC_RESET 1'b1
`define NV_START_RESET 7'h00
`define NV_UNLOCK_KEY 8'hBE
`define NV_COUNT_MAX 8'hFF
`define NV_CRC_POLY 8'h07
`define NV_LAST_INDEX 5'h1F
`define NV_CLOCK_HZ 20000000
`define NV_ERASE_TIME_MS 115
`define NV_PROG_TIME_MS 115
`define NV_ERASE_CYCLES ((`NV_CLOCK_HZ / 1000) * `NV_ERASE_TIME_MS)
`define NV_PROG_CYCLES ((`NV_CLOCK_HZ / 1000) * `NV_PROG_TIME_MS)
`endif

// [pkg/nv_control_pkg.sv]
// types shared by the control front end and the memory engine
`default_nettype none
package nv_control_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ERASE = 3'h1, ST_PROG = 3'h3, ST_WAIT = 3'h2,
    ST_LOAD = 3'h4, ST_SAVE = 3'h6
  } nv_state_type;
  typedef enum logic [2:0] {
    I_IDLE = 3'h0, I_ADDR = 3'h1, I_ACK = 3'h3, I_WRITE = 3'h2,
    I_READ = 3'h6, I_MACK = 3'h7
  } i2c_state_type;
endpackage : nv_control_pkg
`default_nettype wire

// [pkg/nv_link_if.sv]
// link between the register front end and the memory engine
`timescale 1ns/10ps
`default_nettype none
interface nv_link_if;
  logic load_req;
  logic save_req;
  logic erase_go;
  logic prog_go;
  logic auto_crc;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic busy;
  logic loading;
  logic idle;
  logic crc_error;
  logic load_done;
  logic save_done;
  logic [7:0] cycle_count;
  logic [4:0] cfg_addr;
  logic [7:0] cfg_data;
  logic cfg_we;
  logic [7:0] cfg_rdata;
  modport ctrl (output load_req, save_req, erase_go, prog_go, auto_crc, rd_addr, cfg_rdata,
    input rd_data, busy, loading, idle, crc_error, load_done, save_done, cycle_count,
    cfg_addr, cfg_data, cfg_we);
  modport engine (input load_req, save_req, erase_go, prog_go, auto_crc, rd_addr, cfg_rdata,
    output rd_data, busy, loading, idle, crc_error, load_done, save_done, cycle_count,
    cfg_addr, cfg_data, cfg_we);
endinterface : nv_link_if
`default_nettype wire

// [hdl/nv_engine.sv]
// memory engine: nonvolatile array, shadow sram, load/save/erase/program sequencing
`include "nv_control_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module nv_engine import nv_control_pkg::*; #(
  parameter int ERASE_CYCLES = `NV_ERASE_CYCLES,
  parameter int PROG_CYCLES = `NV_PROG_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  nv_link_if.engine link
);
  // blank at power-up, as after an erase; otherwise the boot load would copy unknown bytes
  logic [7:0] nv_mem [0:31] = '{default: 8'h00};
  logic [7:0] sram [0:31];
  nv_state_type state;
  logic [4:0] idx;
  logic [7:0] crc;
  logic [31:0] timer;
  logic prog_after;
  logic [7:0] load_byte;
  logic [7:0] prog_word;
  logic last;
  logic erase_start;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `NV_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8

  // status and reads; done strobes are combinational so the request bit clears as we go idle
  assign last = idx == `NV_LAST_INDEX;
  assign load_byte = nv_mem[idx];
  assign prog_word = (last && link.auto_crc) ? crc : sram[idx];
  assign link.rd_data = nv_mem[link.rd_addr];
  assign link.busy = state == ST_ERASE || state == ST_PROG || state == ST_WAIT;
  assign link.loading = state == ST_LOAD;
  assign link.idle = state == ST_IDLE;
  assign link.load_done = state == ST_LOAD && last;
  assign link.save_done = state == ST_SAVE && link.cfg_addr == `NV_LAST_INDEX - 5'h01;
  assign erase_start = link.idle && link.erase_go;

  // array writes; no reset, the array keeps its bytes across a reset
  always_ff @(posedge clock_i) begin
    if (state == ST_LOAD) begin
      sram[idx] <= load_byte;
    end
    if (state == ST_SAVE) begin
      sram[link.cfg_addr] <= link.cfg_rdata;
    end
    if (state == ST_PROG) begin
      nv_mem[idx] <= prog_word;
    end
    if (erase_start) begin
      for (int i = 0; i < 32; i++) begin
        nv_mem[i] <= 8'h00;
      end
    end
  end

  // sequencer; a load runs straight out of reset
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= ST_LOAD;
      idx <= 5'h00;
      crc <= 8'h00;
      timer <= 32'h0000_0000;
      prog_after <= 1'b0;
      link.crc_error <= 1'b0;
      link.cycle_count <= 8'h00;
      link.cfg_addr <= 5'h00;
      link.cfg_data <= 8'h00;
      link.cfg_we <= 1'b0;
    end else begin
      link.cfg_we <= 1'b0;
      case (state)
        ST_IDLE: begin
          idx <= 5'h00;
          crc <= 8'h00;
          link.cfg_addr <= 5'h00;
          if (link.erase_go) begin
            state <= ST_ERASE;
            timer <= 32'(ERASE_CYCLES - 1);
            prog_after <= link.prog_go;
          end else if (link.prog_go) begin
            state <= ST_PROG;
          end else if (link.load_req) begin
            state <= ST_LOAD;
          end else if (link.save_req) begin
            state <= ST_SAVE;
          end
        end
        ST_LOAD: begin
          link.cfg_addr <= idx;
          link.cfg_data <= load_byte;
          link.cfg_we <= !last;
          idx <= idx + 5'h01;
          crc <= crc8(crc, load_byte);
          if (last) begin
            link.crc_error <= load_byte != crc;
            state <= ST_IDLE;
          end
        end
        ST_SAVE: begin
          link.cfg_addr <= link.cfg_addr + 5'h01;
          if (link.save_done) begin
            state <= ST_IDLE;
          end
        end
        ST_PROG: begin
          idx <= idx + 5'h01;
          crc <= crc8(crc, prog_word);
          if (last) begin
            state <= ST_WAIT;
            timer <= 32'(PROG_CYCLES - 1);
          end
        end
        default: begin
          if (timer != 32'h0000_0000) begin
            timer <= timer - 32'h0000_0001;
          end else if (state == ST_ERASE && prog_after) begin
            state <= ST_PROG;
            prog_after <= 1'b0;
          end else begin
            state <= ST_IDLE;
            if (link.cycle_count != `NV_COUNT_MAX) begin
              link.cycle_count <= link.cycle_count + 8'h01;
            end
          end
        end
      endcase
    end
  end

  sequence cycle_req_s;
    link.idle && link.erase_go && link.prog_go;
  endsequence
  sequence erase_entry_s;
    state == ST_ERASE && prog_after && timer == 32'(ERASE_CYCLES - 1);
  endsequence
  load_reset_a: assert property (@(posedge clock_i) !resetn_i |=> state == ST_LOAD)
    else $error("no load after reset");
  combo_cycle_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    cycle_req_s |=> erase_entry_s) else $error("combined cycle not started");
  crc_check_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == ST_LOAD && last) |=> link.crc_error == ($past(load_byte) != $past(crc)))
    else $error("crc error flag wrong");
  auto_crc_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == ST_PROG && last && link.auto_crc) |=> nv_mem[`NV_LAST_INDEX] == $past(crc))
    else $error("stored crc not generated");
  prog_time_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == ST_PROG && last) |=> link.busy && timer == 32'(PROG_CYCLES - 1))
    else $error("program wait wrong");
  busy_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(link.busy) |-> $past(timer) == 32'h0000_0000) else $error("busy dropped early");
  count_sat_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(link.busy) |-> link.cycle_count == (($past(link.cycle_count) == `NV_COUNT_MAX) ?
    `NV_COUNT_MAX : $past(link.cycle_count) + 8'h01)) else $error("cycle count wrong");
  save_end_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    link.save_done |=> link.idle) else $error("save did not finish");
endmodule : nv_engine
`default_nettype wire

// [verif/i2c_host.sv]
// two-wire bus controller model standing in for the host
`timescale 1ns/10ps
`default_nettype none
module i2c_host (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // idle bus: both lines released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask : wait_n
  // phases of 10 clocks keep above the synchroniser minimum of 8
  task automatic send_bit(input logic b);
    sda_low_o <= ~b;
    wait_n(10);
    scl_o <= 1'b1;
    wait_n(10);
    scl_o <= 1'b0;
    wait_n(10);
  endtask : send_bit
  task automatic get_bit(output logic b);
    sda_low_o <= 1'b0;
    wait_n(10);
    scl_o <= 1'b1;
    wait_n(5);
    b = sda_i;
    wait_n(5);
    scl_o <= 1'b0;
    wait_n(10);
  endtask : get_bit
  // also serves as repeated start, since it releases sda with scl low
  task automatic start_bit();
    sda_low_o <= 1'b0;
    wait_n(10);
    scl_o <= 1'b1;
    wait_n(10);
    sda_low_o <= 1'b1;
    wait_n(10);
    scl_o <= 1'b0;
    wait_n(10);
  endtask : start_bit
  task automatic stop_bit();
    sda_low_o <= 1'b1;
    wait_n(10);
    scl_o <= 1'b1;
    wait_n(10);
    sda_low_o <= 1'b0;
    wait_n(10);
  endtask : stop_bit
  task automatic write_byte(input logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    get_bit(b);
  endtask : write_byte
  // last byte is refused so the device lets go of the line
  task automatic read_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    send_bit(last);
  endtask : read_byte
endmodule : i2c_host
`default_nettype wire

// [verif/nv_memory_control_access_bench.sv]
// self-checking bench for the nonvolatile memory control block
`timescale 1ns/10ps
`default_nettype none
module nv_memory_control_access_bench;
  logic clock_i;
  logic resetn_i;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe_o;
  logic sda_line;
  logic [4:0] cfg_addr;
  logic [7:0] cfg_data;
  logic cfg_we;
  logic [7:0] cfg_rdata;
  logic [7:0] live [32];
  logic [7:0] rd [4];
  int miscompares;
  int total_checks;
  // device address (arbitrary value) and a shortened cycle time shared with the instance
  localparam logic [6:0] DEV = 7'h5A;
  localparam int CYCLES = 3000;
  localparam int SETTLE = 40;
  // open-drain wire with pull-up
  assign sda_line = (sda_oe_o ? sda_o : 1'b1) & ~sda_low;
  // live register file: combinational read, one write per strobe
  assign cfg_rdata = live[cfg_addr];
  always @(posedge clock_i) begin
    if (cfg_we) live[cfg_addr] <= cfg_data;
  end
  nv_control_top #(.DEV_ADDR(DEV), .ERASE_CYCLES(CYCLES), .PROG_CYCLES(CYCLES)) u_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cfg_addr_o(cfg_addr),
    .cfg_data_o(cfg_data), .cfg_we_o(cfg_we), .cfg_rdata_i(cfg_rdata)
  );
  i2c_host u_host (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.start_bit();
    u_host.write_byte({DEV, 1'b0});
    u_host.write_byte(a);
    u_host.write_byte(d);
    u_host.stop_bit();
  endtask : wr
  task automatic rdn(input logic [7:0] a, input int n);
    u_host.start_bit();
    u_host.write_byte({DEV, 1'b0});
    u_host.write_byte(a);
    u_host.start_bit();
    u_host.write_byte({DEV, 1'b1});
    for (int i = 0; i < n; i++) u_host.read_byte(i == n - 1, rd[i]);
    u_host.stop_bit();
  endtask : rdn
  // key written as the transaction just before
  task automatic unlock();
    wr(8'h38, 8'hBE);
  endtask : unlock
  task automatic t_refused();
    unlock();
    wr(8'h33, 8'h00);
    wr(8'h31, 8'h12);
    rdn(8'h31, 1);
    check8("busy no key", 8'h00, rd[0] & 8'h04);
    wr(8'h31, 8'h11);
    rdn(8'h31, 1);
    check8("prog no key", 8'h00, rd[0] & 8'h04);
  endtask : t_refused
  task automatic t_erase();
    unlock();
    wr(8'h31, 8'h12);
    rdn(8'h31, 1);
    check8("busy erase", 8'h04, rd[0] & 8'h04);
    rdn(8'h34, 1);
    check8("data busy", 8'h00, rd[0]);
    u_host.wait_n(CYCLES);
    rdn(8'h31, 1);
    check8("busy end", 8'h00, rd[0] & 8'h04);
    rdn(8'h30, 1);
    check8("count erase", 8'h01, rd[0]);
  endtask : t_erase
  task automatic t_load();
    wr(8'h31, 8'h18);
    u_host.wait_n(SETTLE);
    rdn(8'h31, 1);
    check8("ctrl load", 8'h10, rd[0]);
    check8("live blank", 8'h00, live[5]);
  endtask : t_load
  task automatic t_save_prog();
    for (int i = 0; i < 31; i++) live[i] = 8'h40 + 8'(i);
    wr(8'h31, 8'h50);
    u_host.wait_n(SETTLE);
    rdn(8'h31, 1);
    check8("save clear", 8'h00, rd[0] & 8'h40);
    unlock();
    wr(8'h31, 8'h13);
    rdn(8'h31, 1);
    check8("busy prog", 8'h04, rd[0] & 8'h04);
    u_host.wait_n(2 * CYCLES);
    rdn(8'h30, 1);
    check8("count once", 8'h02, rd[0]);
    live[5] = 8'h00;
    wr(8'h31, 8'h18);
    u_host.wait_n(SETTLE);
    rdn(8'h31, 1);
    check8("crc ok", 8'h10, rd[0]);
    check8("live back", 8'h45, live[5]);
  endtask : t_save_prog
  task automatic t_window();
    wr(8'h33, 8'h23);
    rdn(8'h33, 3);
    check8("start reg", 8'h23, rd[0]);
    check8("first byte", 8'h43, rd[1]);
    check8("next byte", 8'h44, rd[2]);
    rdn(8'h34, 2);
    check8("lock ended", 8'h43, rd[0]);
    check8("lock next", 8'h44, rd[1]);
    rdn(8'h33, 1);
    check8("start kept", 8'h23, rd[0]);
  endtask : t_window
  task automatic t_crc_err();
    live[0] = 8'hAA;
    wr(8'h31, 8'h40);
    u_host.wait_n(SETTLE);
    unlock();
    wr(8'h31, 8'h01);
    // array holds nonzero bytes here, so a zero read proves the refusal
    rdn(8'h34, 1);
    check8("data refused", 8'h00, rd[0]);
    u_host.wait_n(CYCLES);
    rdn(8'h30, 1);
    check8("count prog", 8'h03, rd[0]);
    wr(8'h31, 8'h08);
    u_host.wait_n(SETTLE);
    rdn(8'h31, 1);
    check8("crc error", 8'h20, rd[0]);
  endtask : t_crc_err
  // mid-run reset: the array keeps its bytes and the boot load brings them back
  task automatic t_reset();
    live[0] = 8'h00;
    resetn_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    u_host.wait_n(SETTLE);
    check8("reset load", 8'hAA, live[0]);
    rdn(8'h31, 1);
    check8("reset crc", 8'h30, rd[0]);
  endtask : t_reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // free-running 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (90000) @(posedge clock_i);
    miscompares++;
    wrap_up();
  end
  initial begin
    miscompares = 0;
    total_checks = 0;
    resetn_i = 1'b0;
    for (int i = 0; i < 32; i++) live[i] = 8'h5C;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    // no reads while the power-on load runs
    u_host.wait_n(SETTLE);
    check8("boot load", 8'h00, live[5]);
    rdn(8'h33, 1);
    check8("start reset", 8'h00, rd[0]);
    t_refused();
    t_erase();
    t_load();
    t_save_prog();
    t_window();
    t_crc_err();
    t_reset();
    wrap_up();
  end
endmodule : nv_memory_control_access_bench
`default_nettype wire
